// file: include/mode_regs_pkg.sv
// package: register map, field positions and encodings of the mode control bank
package mode_regs_pkg;
    localparam logic [6:0] addr_reset = 7'h00;
    localparam logic [6:0] addr_format = 7'h01;
    localparam logic [6:0] addr_output = 7'h02;
    localparam logic [6:0] addr_pat_high = 7'h03;
    localparam logic [6:0] addr_pat_low = 7'h04;
    localparam int reset_bit = 7;
    localparam int duty_bit = 7;
    localparam int scramble_bit = 6;
    localparam int signed_bit = 5;
    localparam int sleep_bit = 4;
    localparam int nap2_bit = 3;
    localparam int nap1_bit = 0;
    localparam int current_lsb = 5;
    localparam int term_bit = 4;
    localparam int outputs_disable_bit = 3;
    localparam int pattern_bit = 2;
    localparam int lane_lsb = 0;
    localparam logic [7:0] reg_reset_val = 8'h00;
    localparam int word_bits = 16;
    localparam int addr_first = 14;
    localparam int data_first = 7;
    localparam logic [4:0] bit_count_done = 5'h10;
    localparam logic [1:0] lanes_two = 2'h0;
    localparam logic [1:0] lanes_four = 2'h1;
    localparam logic [1:0] lanes_one = 2'h2;

    typedef struct packed {
        logic duty_stabilizer_disable;
        logic output_scramble_enable;
        logic signed_format_select;
        logic sleep;
        logic nap_ch1;
        logic nap_ch2;
        logic [2:0] driver_current_select;
        logic internal_termination_enable;
        logic outputs_disable;
        logic pattern_enable;
        logic [1:0] lane_count_select;
    } mode_ctrl_t;
endpackage

// file: core/mode_regs.sv
// mode control register bank behind a four-wire serial port, with output formatting
`timescale 1ns/1ps

// Functional notes
// - bit 7 set turns duty stabilizer off
// - sleep bit powers down both channels
// - nap bits idle each channel independently
// - bits 7..5 pick driver current code
// - bit 3 forces both channel data outputs to zero
// - bit 2 enables output test pattern
// - address 03h gives pattern bits 15..8
// - address 04h gives pattern bits 7..0
// - scramble xors lsb into upper bits
// - pattern overrides coding and scrambling
// - reset bit clears all, self-clears
// - 16-bit word, read leaves register untouched
module mode_regs #(
    parameter int data_width = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    input wire logic sdo_in,
    output logic sdo_out,
    output logic sdo_oe,
    input wire logic [data_width-1:0] ch1_sample,
    input wire logic [data_width-1:0] ch2_sample,
    output logic [data_width-1:0] ch1_data,
    output logic [data_width-1:0] ch2_data,
    output mode_regs_pkg::mode_ctrl_t mode,
    output logic ch1_active,
    output logic ch2_active
);
    // ----------------------------------------------------------------
    // serial capture
    // ----------------------------------------------------------------
    logic sck_d_r;
    logic [4:0] count_r;
    logic [15:0] shift_r;
    logic [7:0] read_r;
    logic reading_r;
    logic [7:0] format_r;
    logic [7:0] output_r;
    logic [7:0] pat_high_r;
    logic [7:0] pat_low_r;
    logic sck_rise;
    logic [15:0] word_nxt;
    logic word_done;
    logic [7:0] read_nxt;

    // sck is sampled as a plain input; it must be well below clk/2
    assign sck_rise = sck && !sck_d_r && !cs_n;
    assign word_nxt = {shift_r[14:0], sdi};
    assign word_done = sck_rise && count_r == mode_regs_pkg::bit_count_done - 5'h01;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sck_d_r <= 1'b0;
        end else begin
            sck_d_r <= sck;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || cs_n) begin
            count_r <= 5'h00;
            shift_r <= 16'h0000;
        end else if (sck_rise && count_r != mode_regs_pkg::bit_count_done) begin
            count_r <= count_r + 5'h01;
            shift_r <= word_nxt;
        end
    end

    always_comb begin
        // at the 8th rise the address still sits in the low bits of the word
        case (word_nxt[6:0])
            mode_regs_pkg::addr_format: read_nxt = format_r;
            mode_regs_pkg::addr_output: read_nxt = output_r;
            mode_regs_pkg::addr_pat_high: read_nxt = pat_high_r;
            mode_regs_pkg::addr_pat_low: read_nxt = pat_low_r;
            default: read_nxt = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // read-back on the open-drain output
    // ----------------------------------------------------------------
    // address is known after bit 8; data shifts out during the data bits
    always_ff @(posedge clk) begin
        if (!rst_n || cs_n) begin
            read_r <= 8'h00;
            reading_r <= 1'b0;
        end else if (sck_rise && count_r == 5'h07) begin
            read_r <= read_nxt;
            reading_r <= word_nxt[7];
        end else if (sck && !sck_d_r && count_r > 5'h08 && count_r < mode_regs_pkg::bit_count_done) begin
            read_r <= {read_r[6:0], 1'b0};
        end
    end

    // open drain: only ever pulls low
    assign sdo_out = 1'b0;
    assign sdo_oe = reading_r && !read_r[7] && !cs_n;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    logic wr;
    logic [6:0] wr_addr;
    logic soft_reset;
    assign wr = word_done && !word_nxt[15];
    assign wr_addr = word_nxt[mode_regs_pkg::addr_first -: 7];
    assign soft_reset = wr && wr_addr == mode_regs_pkg::addr_reset && word_nxt[mode_regs_pkg::reset_bit];

    always_ff @(posedge clk) begin
        if (!rst_n || soft_reset) begin
            format_r <= mode_regs_pkg::reg_reset_val;
            output_r <= mode_regs_pkg::reg_reset_val;
            pat_high_r <= mode_regs_pkg::reg_reset_val;
            pat_low_r <= mode_regs_pkg::reg_reset_val;
        end else if (wr) begin
            case (wr_addr)
                mode_regs_pkg::addr_format: format_r <= word_nxt[7:0];
                mode_regs_pkg::addr_output: output_r <= word_nxt[7:0];
                mode_regs_pkg::addr_pat_high: pat_high_r <= word_nxt[7:0];
                mode_regs_pkg::addr_pat_low: pat_low_r <= word_nxt[7:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // decoded controls
    // ----------------------------------------------------------------
    always_comb begin
        mode.duty_stabilizer_disable = format_r[mode_regs_pkg::duty_bit];
        mode.output_scramble_enable = format_r[mode_regs_pkg::scramble_bit];
        mode.signed_format_select = format_r[mode_regs_pkg::signed_bit];
        mode.sleep = format_r[mode_regs_pkg::sleep_bit];
        mode.nap_ch1 = format_r[mode_regs_pkg::nap1_bit];
        mode.nap_ch2 = format_r[mode_regs_pkg::nap2_bit];
        mode.driver_current_select = output_r[mode_regs_pkg::current_lsb +: 3];
        mode.internal_termination_enable = output_r[mode_regs_pkg::term_bit];
        mode.outputs_disable = output_r[mode_regs_pkg::outputs_disable_bit];
        mode.pattern_enable = output_r[mode_regs_pkg::pattern_bit];
        mode.lane_count_select = output_r[mode_regs_pkg::lane_lsb +: 2];
    end

    assign ch1_active = !mode.sleep && !mode.nap_ch1;
    assign ch2_active = !mode.sleep && !mode.nap_ch2;

    // ----------------------------------------------------------------
    // output data formatting
    // ----------------------------------------------------------------
    logic [15:0] pattern;
    assign pattern = {pat_high_r, pat_low_r};

    function automatic logic [data_width-1:0] fmt(input logic [data_width-1:0] s, input logic active);
        logic [data_width-1:0] v;
        v = s;
        if (mode.signed_format_select) begin
            v[data_width-1] = !v[data_width-1];
        end
        if (mode.output_scramble_enable) begin
            v[data_width-1:1] = v[data_width-1:1] ^ {(data_width-1){v[0]}};
        end
        if (mode.pattern_enable) begin
            v = pattern[data_width-1:0];
        end
        if (mode.outputs_disable || !active) begin
            v = '0;
        end
        return v;
    endfunction

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ch1_data <= '0;
            ch2_data <= '0;
        end else begin
            ch1_data <= fmt(ch1_sample, ch1_active);
            ch2_data <= fmt(ch2_sample, ch2_active);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence write_done_s;
        wr && wr_addr == mode_regs_pkg::addr_pat_low;
    endsequence

    soft_reset_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
        soft_reset |=> format_r == 8'h00 && output_r == 8'h00 && pattern == 16'h0000)
        else $error("soft reset left a register set");
    pattern_low_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        write_done_s and !soft_reset |=> pattern[7:0] == $past(word_nxt[7:0]))
        else $error("low pattern byte not stored");
    pattern_high_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && wr_addr == mode_regs_pkg::addr_pat_high |=> pattern[15:8] == $past(word_nxt[7:0]))
        else $error("high pattern byte not stored");
    read_no_update_a: assert property (@(posedge clk) disable iff (!rst_n)
        word_done && word_nxt[15] |=> $stable(format_r) && $stable(output_r))
        else $error("read changed a register");
    sleep_both_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        format_r[4] |-> !ch1_active && !ch2_active)
        else $error("sleep left a channel active");
    nap_split_a: assert property (@(posedge clk) disable iff (!rst_n)
        !format_r[4] |-> ch1_active == !format_r[0] && ch2_active == !format_r[3])
        else $error("nap decode wrong");
    pattern_shown_a: assert property (@(posedge clk) disable iff (!rst_n)
        output_r[2] && !output_r[3] && ch1_active && $stable(output_r) && $stable(pattern)
        |=> ch1_data == pattern)
        else $error("pattern not shown");
    outputs_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        output_r[3] && $stable(output_r) |=> ch1_data == 16'h0000 && ch2_data == 16'h0000)
        else $error("outputs not disabled");
    current_field_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && wr_addr == mode_regs_pkg::addr_output
        |=> mode.driver_current_select == $past(word_nxt[mode_regs_pkg::current_lsb +: 3]))
        else $error("current field wrong");
endmodule

// file: dv/serial_host.sv
// host model driving the four-wire serial configuration port
`timescale 1ns/1ps
module serial_host (
    input wire logic clk,
    input wire logic sdo_wire,
    output logic cs_n,
    output logic sck,
    output logic sdi,
    output logic [7:0] rd_data,
    output logic rd_done
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
        rd_data = 8'h00;
        rd_done = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // sixteen bit word
    // three clk per sck phase keeps clear of the two-cycle minimum
    task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d);
        logic [15:0] w;
        logic [7:0] q;
        w = {rw, a, d};
        q = 8'h00;
        cs_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            sdi = w[15 - i];
            tick(3);
            sck = 1'b1;
            tick(3);
            // the first data bit stands from the 8th rise through the 9th
            if (i >= 8) begin
                q[15 - i] = sdo_wire;
            end
            sck = 1'b0;
        end
        tick(3);
        cs_n = 1'b1;
        // released line must not keep its last value
        sdi = ~sdi;
        if (rw) begin
            rd_data = q;
            rd_done = 1'b1;
            tick(1);
            rd_done = 1'b0;
        end
        tick(2);
    endtask
    task automatic soft_reset();
        xfer(1'b0, mode_regs_pkg::addr_reset, 8'h80);
    endtask
endmodule

// file: dv/tb.sv
// self-checking bench for the mode control register bank
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, sck, sdi, sdo_out, sdo_oe, sdo_w, rd_done, a1, a2;
    logic obs_stb = 1'b0;
    logic [1:0] obs_sel = 2'h0;
    logic [7:0] rd_data, ph, pl;
    logic [7:0] r[0:7];
    logic [15:0] s1 = 16'h0000, s2 = 16'h0000, d1, d2, obs_val;
    mode_regs_pkg::mode_ctrl_t mode;
    logic [7:0] exp_b[$];
    logic [15:0] exp_w[$];
    int mismatches = 0, compares = 0, cycles = 0;
    always #12.5 clk = ~clk;
    // pull-up on the open-drain readback line
    assign sdo_w = ~sdo_oe;
    assign obs_val = obs_sel == 2'h0 ? d1 : obs_sel == 2'h1 ? d2 :
        obs_sel == 2'h2 ? {2'h0, mode} : {13'h0, sdo_out, a1, a2};
    serial_host host (.clk(clk), .sdo_wire(sdo_w), .cs_n(cs_n), .sck(sck), .sdi(sdi),
        .rd_data(rd_data), .rd_done(rd_done));
    mode_regs dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_in(sdo_w),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ch1_sample(s1), .ch2_sample(s2), .ch1_data(d1),
        .ch2_data(d2), .mode(mode), .ch1_active(a1), .ch2_active(a2));
    task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t readback got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_word(input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t output got %h expected %h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        $display("counts: compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            $display("ERROR %0t timeout", $time);
            stop_test();
        end else begin
            if (rd_done === 1'b1)
                cmp_byte(exp_b.pop_front(), rd_data);
            if (obs_stb === 1'b1)
                cmp_word(exp_w.pop_front(), obs_val);
        end
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        r[a[2:0]] = d;
        host.xfer(1'b0, a, d);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_b.push_back(e);
        host.xfer(1'b1, a, 8'($urandom()));
    endtask
    task automatic obs(input logic [1:0] sel, input logic [15:0] e);
        exp_w.push_back(e);
        obs_sel = sel;
        obs_stb = 1'b1;
        host.tick(1);
        obs_stb = 1'b0;
    endtask
    function automatic logic [15:0] fmt(input logic [15:0] s, input logic sg, input logic sc);
        logic [15:0] f;
        f = s;
        f[15] = f[15] ^ sg;
        if (sc)
            f[15:1] = f[15:1] ^ {15{f[0]}};
        return f;
    endfunction
    initial begin
        void'($urandom(32'h7b650306));
        host.tick(3);
        rst_n = 1'b1;
        host.soft_reset();
        for (int a = 0; a < 6; a++) rd(7'(a), 8'h00);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            wr(7'h01, 8'($urandom()));
            wr(7'h02, {8'($urandom()) & 8'hfc} | 8'(i));
            // code 011 is not to be written
            if (r[2][7:5] == 3'h3) wr(7'h02, r[2] ^ 8'h20);
            wr(7'h03, 8'($urandom()));
            wr(7'h04, 8'($urandom()));
            for (int k = 0; k < 8; k++) rd(7'(k / 2 + 1), r[k / 2 + 1]);
            obs(2'h2, {2'h0, r[1][7:4], r[1][0], r[1][3], r[2]});
        end
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            wr(7'h01, {3'h0, c[2], c[1], 2'h0, c[0]});
            obs(2'h3, {13'h0, 1'b0, !c[2] && !c[0], !c[2] && !c[1]});
        end
        $display("test power done");
        wr(7'h02, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(7'h01, {1'b0, c[1], c[0], 5'h00});
            s1 = 16'($urandom());
            s2 = 16'($urandom());
            host.tick(2);
            obs(2'h0, fmt(s1, c[0], c[1]));
            obs(2'h1, fmt(s2, c[0], c[1]));
        end
        ph = 8'($urandom());
        pl = 8'($urandom());
        wr(7'h03, ph);
        wr(7'h04, pl);
        wr(7'h02, 8'h04);
        obs(2'h0, {ph, pl});
        obs(2'h1, {ph, pl});
        wr(7'h02, 8'h0c);
        obs(2'h0, 16'h0000);
        obs(2'h1, 16'h0000);
        $display("test format done");
        host.soft_reset();
        for (int a = 1; a < 5; a++) rd(7'(a), 8'h00);
        $display("test soft reset done");
        stop_test();
    end
endmodule
